// ==== verilog/dual_port_ram_cell.sv ====
// Dual-port 4 Kb RAM cell with width settings over APB
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps

module dual_port_ram_cell (
	input  wire logic        core_clk,         // Core clock, 250 MHz
	input  wire logic        rst_b,            // Async reset, active low
	input  wire logic        psel,             // APB select
	input  wire logic        penable,          // APB enable
	input  wire logic        pwrite,           // APB direction
	input  wire logic [11:0] paddr,            // APB byte address
	input  wire logic [31:0] pwdata,           // APB write data
	output logic      [31:0] prdata,           // APB read data
	output logic             pready,           // APB ready
	output logic             pslverr,          // APB error
	input  wire logic        write_clk,        // Write port clock
	input  wire logic        write_clk_enable, // Write clock enable
	input  wire logic        write_enable,     // Write enable
	input  wire logic [10:0] write_addr_bus,   // Write address
	input  wire logic [15:0] write_data_bus,   // Write data lanes
	input  wire logic [15:0] write_mask_n,     // Bit mask, active low
	input  wire logic        read_clk,         // Read port clock
	input  wire logic        read_clk_enable,  // Read clock enable
	input  wire logic        read_enable,      // Read enable
	input  wire logic [10:0] read_addr_bus,    // Read address
	output logic      [15:0] read_data_bus     // Read data lanes
);

	//------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------
	ram_pkg::wr_port_t wr_in;        // Write pins as one carrier
	ram_pkg::wr_port_t ws1;          // Write sync stage 1
	ram_pkg::wr_port_t ws2;          // Write sync stage 2
	ram_pkg::rd_port_t rd_in;        // Read pins as one carrier
	ram_pkg::rd_port_t rs1;          // Read sync stage 1
	ram_pkg::rd_port_t rs2;          // Read sync stage 2
	logic              wclk_d;       // Previous write clock level
	logic              rclk_d;       // Previous read clock level
	logic [2:0]        arm;          // Edge detect warm-up
	logic [1:0]        wr_code;      // Write width code
	logic [1:0]        rd_code;      // Read width code
	logic [15:0]       wr_count;     // Writes taken
	logic [15:0]       rd_count;     // Reads taken
	logic [15:0]       mem [ram_pkg::ROWS]; // 4096 storage bits

	//------------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------------
	assign wr_in = {write_clk, write_clk_enable, write_enable,
	                write_addr_bus, write_data_bus, write_mask_n};
	assign rd_in = {read_clk, read_clk_enable, read_enable, read_addr_bus};

	// Two flops per pin, then one for edge history
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ws1    <= '0;
			ws2    <= '0;
			rs1    <= '0;
			rs2    <= '0;
			wclk_d <= 1'b0;
			rclk_d <= 1'b0;
		end else begin
			ws1    <= wr_in;
			ws2    <= ws1;
			rs1    <= rd_in;
			rs2    <= rs1;
			wclk_d <= ws2.clk;
			rclk_d <= rs2.clk;
		end
	end

	// Blocks a false edge before history is valid
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			arm <= ram_pkg::ARM_RESET;
		end else begin
			arm <= {arm[1:0], 1'b1};
		end
	end

	//------------------------------------------------------------------
	// Port events
	//------------------------------------------------------------------
	// Only rising edges count; an inverted pin clock gives falling
	wire wclk_rise = ws2.clk & ~wclk_d & arm[2];
	wire rclk_rise = rs2.clk & ~rclk_d & arm[2];
	// Clock enable gates the whole port
	wire wr_fire   = wclk_rise & ws2.ce & ws2.en;
	wire rd_fire   = rclk_rise & rs2.ce & rs2.en;

	//------------------------------------------------------------------
	// Address to storage position
	//------------------------------------------------------------------
	// Bit address = word address times width; unused high bits drop
	wire [2:0]  wr_sh   = {1'b0, wr_code} + 3'd1;
	wire [2:0]  rd_sh   = {1'b0, rd_code} + 3'd1;
	wire [14:0] wr_lin  = {4'h0, ws2.addr} << wr_sh;
	wire [14:0] rd_lin  = {4'h0, rs2.addr} << rd_sh;
	wire [7:0]  wr_row  = wr_lin[11:4];
	wire [3:0]  wr_col  = wr_lin[3:0];
	wire [7:0]  rd_row  = rd_lin[11:4];
	wire [3:0]  rd_col  = rd_lin[3:0];

	//------------------------------------------------------------------
	// Lane mapping, each port on its own width
	//------------------------------------------------------------------
	logic [15:0] wr_packed;          // Write word packed low
	logic [15:0] rd_lanes;           // Read word on its lanes
	wire  [15:0] wr_lane_in = ws2.data & ram_pkg::LANE_MASK[wr_code];

	// Gathers the write lanes
	lane_map u_wr_map (
		.width_code (wr_code),
		.lane_bus   (wr_lane_in),
		.packed_in  (16'h0000),
		.packed_out (wr_packed),
		.lane_out   ()
	);

	//------------------------------------------------------------------
	// Write path
	//------------------------------------------------------------------
	wire        wr_is16   = (wr_code == ram_pkg::W16);
	wire [15:0] wr_ones   = ram_pkg::WORD_ONES[wr_code];
	// Mask acts only in 16-bit mode, else the word's own slot
	wire [15:0] wr_bit_en = wr_is16 ? ~ws2.mask_n : (wr_ones << wr_col);
	wire [15:0] wr_bit_d  = wr_packed << wr_col;
	wire [15:0] wr_old    = mem[wr_row];
	wire [15:0] wr_new    = (wr_old & ~wr_bit_en) | (wr_bit_d & wr_bit_en);

	// Storage array, no reset
	always_ff @(posedge core_clk) begin
		if (wr_fire) begin
			mem[wr_row] <= wr_new;
		end
	end

	//------------------------------------------------------------------
	// Read path
	//------------------------------------------------------------------
	wire [15:0] rd_word   = mem[rd_row];
	wire [15:0] rd_packed = (rd_word >> rd_col) & ram_pkg::WORD_ONES[rd_code];

	// Spreads the read word onto its lanes
	lane_map u_rd_map (
		.width_code (rd_code),
		.lane_bus   (16'h0000),
		.packed_in  (rd_packed),
		.packed_out (),
		.lane_out   (rd_lanes)
	);

	// Output register loads on a read, holds otherwise
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			read_data_bus <= '0;
		end else if (rd_fire) begin
			read_data_bus <= rd_lanes;
		end
	end

	//------------------------------------------------------------------
	// APB slave
	//------------------------------------------------------------------
	wire        apb_acc  = psel & penable & ~pready; // Access, no answer yet
	wire        apb_done = psel & penable & pready;  // Completing edge
	wire        hit_cfg  = (paddr == ram_pkg::OFF_CFG);
	wire        hit_stat = (paddr == ram_pkg::OFF_STAT);
	wire        apb_hit  = hit_cfg | hit_stat;
	wire [31:0] cfg_word = 32'(wr_code) << ram_pkg::CFG_WR_LSB |
	                       32'(rd_code) << ram_pkg::CFG_RD_LSB;
	wire [31:0] rd_mux   = hit_cfg  ? cfg_word :
	                       hit_stat ? {rd_count, wr_count} : 32'h0000_0000;

	// One wait state, then answer for one cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= apb_acc;
			pslverr <= apb_acc & ~apb_hit;
			prdata  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Width settings, taken on the completing edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_code <= ram_pkg::CFG_RESET;
			rd_code <= ram_pkg::CFG_RESET;
		end else if (apb_done && pwrite && hit_cfg) begin
			wr_code <= pwdata[ram_pkg::CFG_WR_LSB +: 2];
			rd_code <= pwdata[ram_pkg::CFG_RD_LSB +: 2];
		end
	end

	// Access counters, wrap silently
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_count <= '0;
			rd_count <= '0;
		end else begin
			wr_count <= wr_count + 16'(wr_fire);
			rd_count <= rd_count + 16'(rd_fire);
		end
	end

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// Snapshot of the last write for later comparison
	logic [7:0]  chk_row;  // Row written
	logic [15:0] chk_en;   // Bits enabled
	logic [15:0] chk_dat;  // Bits offered
	logic [15:0] chk_old;  // Row before write
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			chk_row <= '0;
			chk_en  <= '0;
			chk_dat <= '0;
			chk_old <= '0;
		end else if (wr_fire) begin
			chk_row <= wr_row;
			chk_en  <= wr_bit_en;
			chk_dat <= wr_bit_d;
			chk_old <= wr_old;
		end
	end

	// Width code of the last taken read, for the lane check
	logic [1:0]  chk_rd_code; // Read width at last read
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			chk_rd_code <= ram_pkg::CFG_RESET;
		end else if (rd_fire) begin
			chk_rd_code <= rd_code;
		end
	end

	// Pin edge with enables held reaches the array two cycles on
	sequence s_wr_pin_rise;
		!write_clk ##1 (write_clk && write_clk_enable && write_enable)[*2];
	endsequence
	sequence s_rd_pin_rise;
		!read_clk ##1 (read_clk && read_clk_enable && read_enable)[*2];
	endsequence

	// Pin rise taken two edges after it is seen
	a_wr_latency: assert property (arm[2] ##0 s_wr_pin_rise |-> ##1 wr_fire)
		else $error("write edge not taken two cycles after pin rise");
	a_rd_latency: assert property (arm[2] ##0 s_rd_pin_rise |-> ##1 rd_fire)
		else $error("read edge not taken two cycles after pin rise");

	// Stored bits follow the write and its mask
	a_wr_store: assert property (wr_fire |=> (mem[chk_row] & chk_en) == (chk_dat & chk_en))
		else $error("written bits not stored");
	a_mask_keep: assert property (wr_fire |=> (mem[chk_row] & ~chk_en) == (chk_old & ~chk_en))
		else $error("masked bits changed");
	// Narrow writes touch only their own slot
	a_mask_width: assert property (wr_fire && !wr_is16 |-> $countones(wr_bit_en) == (2 << wr_code))
		else $error("mask leaked into narrow write");

	// Read output loads on a taken read only
	a_rd_hold: assert property (!rd_fire |=> $stable(read_data_bus))
		else $error("read output moved without a read");
	a_idle_lanes: assert property (
		(read_data_bus & ~ram_pkg::LANE_MASK[chk_rd_code]) == 16'h0000)
		else $error("read data on an unused lane");
	a_rd_full: assert property (
		rd_fire && rd_code == ram_pkg::W16 |=> read_data_bus == $past(rd_word))
		else $error("16-bit read mismatch");

	// Clock enable silences its whole port
	a_ce_gate: assert property (!ws2.ce |=> $stable(wr_count))
		else $error("write port active with clock enable low");
	a_ce_gate_rd: assert property (
		!rs2.ce |=> $stable(rd_count) && $stable(read_data_bus))
		else $error("read port active with clock enable low");

	// Each pin rise is taken once only
	a_wr_once: assert property (wr_fire |=> !wr_fire)
		else $error("one write edge taken twice");
	a_rd_once: assert property (rd_fire |=> !rd_fire)
		else $error("one read edge taken twice");

	// Word address lands on the row that its width implies
	a_row_w16: assert property (
		wr_fire && wr_code == ram_pkg::W16 |-> wr_row == ws2.addr[7:0])
		else $error("16-bit write on the wrong row");
	a_row_w2: assert property (
		wr_fire && wr_code == ram_pkg::W2 |-> wr_row == ws2.addr[10:3])
		else $error("2-bit write on the wrong row");
	a_row_rd8: assert property (
		rd_fire && rd_code == ram_pkg::W8 |-> rd_row == rs2.addr[8:1])
		else $error("8-bit read from the wrong row");

	// One wait state, a one-cycle answer, unmapped offsets refused
	a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one cycle after access");
	a_apb_refuse: assert property (
		psel && penable && !pready && !apb_hit |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

endmodule : dual_port_ram_cell

// ==== verilog/ram_pkg.sv ====
// Constants, field layouts and carrier types of the dual-port RAM cell
//------------------------------------------------------------------
// Contract
// - 4 Kb store, four widths, separate width settings
// - Ports always 16-bit data, 11-bit address
// - 4-bit: bits 13,9,5,1; 2-bit: 11,3
// - 8-bit: even bits, 9-bit address; 16-bit: all
// - Write mask acts in 16-bit mode only
// - Write and read widths may differ
// - Write clock rise with enable stores data
// - Read clock rise with enable registers word
// - Inverted clock input gives falling-edge operation
// - 16-bit write keeps bits whose mask is high
//------------------------------------------------------------------
package ram_pkg;

	//------------------------------------------------------------------
	// Geometry
	//------------------------------------------------------------------
	localparam int unsigned ADDR_W    = 11;   // Port address width
	localparam int unsigned DATA_W    = 16;   // Port data width
	localparam int unsigned ROWS      = 256;  // Storage rows of 16 bits
	localparam int unsigned CELL_BITS = 4096; // Total storage bits

	//------------------------------------------------------------------
	// Width codes
	//------------------------------------------------------------------
	localparam logic [1:0] W2  = 2'h0; // 2048 x 2
	localparam logic [1:0] W4  = 2'h1; // 1024 x 4
	localparam logic [1:0] W8  = 2'h2; // 512 x 8
	localparam logic [1:0] W16 = 2'h3; // 256 x 16

	// Bus lanes carrying meaning, by width code
	localparam logic [15:0] LANE_MASK [4] = '{16'h0808, 16'h2222, 16'h5555, 16'hffff};
	// Low-packed word ones, by width code
	localparam logic [15:0] WORD_ONES [4] = '{16'h0003, 16'h000f, 16'h00ff, 16'hffff};

	//------------------------------------------------------------------
	// Register map
	//------------------------------------------------------------------
	localparam logic [11:0] OFF_CFG    = 12'h000;      // Width settings
	localparam logic [11:0] OFF_STAT   = 12'h004;      // Access counters
	localparam int unsigned CFG_WR_LSB = 0;            // Write width code
	localparam int unsigned CFG_RD_LSB = 4;            // Read width code
	localparam logic [1:0]  CFG_RESET  = 2'h3;         // Both ports 16-bit
	localparam logic [2:0]  ARM_RESET  = 3'h0;         // Edge detect disarmed

	//------------------------------------------------------------------
	// Carriers for sampled port pins
	//------------------------------------------------------------------
	typedef struct packed {
		logic        clk;    // Port clock level
		logic        ce;     // Clock enable
		logic        en;     // Write enable
		logic [10:0] addr;   // Address bus
		logic [15:0] data;   // Data bus
		logic [15:0] mask_n; // Bit mask, active low
	} wr_port_t;

	typedef struct packed {
		logic        clk;    // Port clock level
		logic        ce;     // Clock enable
		logic        en;     // Read enable
		logic [10:0] addr;   // Address bus
	} rd_port_t;

endpackage : ram_pkg

// ==== verilog/lane_map.sv ====
// Maps between the fixed 16-bit lane bus and a low-packed data word
`timescale 1ns/10ps

module lane_map (
	input  wire logic [1:0]  width_code, // Configured width code
	input  wire logic [15:0] lane_bus,   // Bus in lane positions
	input  wire logic [15:0] packed_in,  // Low-packed word to spread
	output logic      [15:0] packed_out, // Lanes gathered low
	output logic      [15:0] lane_out    // Word spread to lanes
);

	//------------------------------------------------------------------
	// Per-bit gather and spread
	//------------------------------------------------------------------
	for (genvar i = 0; i < 16; i++) begin : g_bit
		// Gather: word bit i from its lane for each width
		wire g16 = lane_bus[i];
		wire g8;
		wire g4;
		wire g2;
		if (i < 8) begin : g_w8
			assign g8 = lane_bus[2*i];        // Even lanes
		end else begin : g_n8
			assign g8 = 1'b0;
		end
		if (i < 4) begin : g_w4
			assign g4 = lane_bus[4*i+1];      // Lanes 1,5,9,13
		end else begin : g_n4
			assign g4 = 1'b0;
		end
		if (i < 2) begin : g_w2
			assign g2 = lane_bus[8*i+3];      // Lanes 3,11
		end else begin : g_n2
			assign g2 = 1'b0;
		end
		assign packed_out[i] = (width_code == ram_pkg::W16) ? g16 :
		                       (width_code == ram_pkg::W8)  ? g8  :
		                       (width_code == ram_pkg::W4)  ? g4  : g2;

		// Spread: lane i from its word bit; idle lanes read zero
		wire s8 = ((i % 2) == 0) ? packed_in[i/2] : 1'b0;
		wire s4 = ((i % 4) == 1) ? packed_in[i/4] : 1'b0;
		wire s2 = ((i % 8) == 3) ? packed_in[i/8] : 1'b0;
		assign lane_out[i] = (width_code == ram_pkg::W16) ? packed_in[i] :
		                     (width_code == ram_pkg::W8)  ? s8 :
		                     (width_code == ram_pkg::W4)  ? s4 : s2;
	end

endmodule : lane_map

// ==== bench/fabric_port_model.sv ====
// Fabric-side model that drives the RAM cell's write and read ports
`timescale 1ns/10ps

module fabric_port_model (
	input  wire logic        core_clk,         // Timing reference
	input  wire logic [1:0]  wr_code,          // Write width code
	input  wire logic [1:0]  rd_code,          // Read width code
	output logic             write_clk,        // Write port clock pin
	output logic             write_clk_enable, // Write clock enable
	output logic             write_enable,     // Write enable
	output logic      [10:0] write_addr_bus,   // Write address
	output logic      [15:0] write_data_bus,   // Write data lanes
	output logic      [15:0] write_mask_n,     // Bit mask, active low
	output logic             read_clk,         // Read port clock pin
	output logic             read_clk_enable,  // Read clock enable
	output logic             read_enable,      // Read enable
	output logic      [10:0] read_addr_bus     // Read address
);
	//------------------------------------------------------------------
	// Lane mapping
	//------------------------------------------------------------------
	// Spreads a low-packed word onto its lanes, other lanes zero
	function automatic logic [15:0] spread(input logic [15:0] w, input logic [1:0] c);
		int          wb;
		logic [15:0] l;
		wb = 2 << c;
		l = 16'h0000;
		for (int k = 0; k < wb; k++) begin
			l[k * (16 / wb) + ((c == 2'h0) ? 3 : (c == 2'h1) ? 1 : 0)] = w[k];
		end
		return l;
	endfunction : spread

	//------------------------------------------------------------------
	// Port activity
	//------------------------------------------------------------------
	// Parks both clock pins at a level with both enables low
	task automatic set_idle(input logic inv);
		@(posedge core_clk);
		write_enable <= 1'b0;
		read_enable <= 1'b0;
		write_clk <= inv;
		read_clk <= inv;
		repeat (6) @(posedge core_clk);
	endtask : set_idle

	// One write; unused address bits zero, mask low outside 16-bit
	task automatic port_write(input logic [10:0] a, input logic [15:0] w, input logic [15:0] m,
		input logic ce, input logic en, input logic inv);
		@(posedge core_clk);
		write_clk_enable <= ce;
		write_enable <= en;
		write_addr_bus <= a & (11'h7ff >> wr_code);
		write_data_bus <= spread(w, wr_code);
		write_mask_n <= (wr_code == ram_pkg::W16) ? m : 16'h0000;
		repeat (4) @(posedge core_clk);
		write_clk <= ~inv;
		repeat (4) @(posedge core_clk);
		write_clk <= inv;
		repeat (8) @(posedge core_clk);
		write_enable <= 1'b0;
		write_data_bus <= spread(~w, wr_code); // Stale data no longer valid
	endtask : port_write

	// One read request
	task automatic port_read(input logic [10:0] a, input logic ce, input logic en,
		input logic inv);
		@(posedge core_clk);
		read_clk_enable <= ce;
		read_enable <= en;
		read_addr_bus <= a & (11'h7ff >> rd_code);
		repeat (4) @(posedge core_clk);
		read_clk <= ~inv;
		repeat (4) @(posedge core_clk);
		read_clk <= inv;
		repeat (8) @(posedge core_clk);
		read_enable <= 1'b0;
	endtask : port_read

	// Idle levels at time zero
	initial begin
		write_clk = 1'b0;
		write_clk_enable = 1'b0;
		write_enable = 1'b0;
		write_addr_bus = 11'h000;
		write_data_bus = 16'h0000;
		write_mask_n = 16'h0000;
		read_clk = 1'b0;
		read_clk_enable = 1'b0;
		read_enable = 1'b0;
		read_addr_bus = 11'h000;
	end
endmodule : fabric_port_model

// ==== bench/dual_port_ram_cell_tb.sv ====
// Self-checking testbench of the dual-port RAM cell
`timescale 1ns/10ps

module dual_port_ram_cell_tb;
	logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr; // Core and APB
	logic [11:0] paddr;   // APB address
	logic [31:0] pwdata, prdata, rd; // APB data
	logic        wclk, wce, wen, rclk, rce, ren, err; // Port pins
	logic [10:0] waddr, raddr; // Port addresses
	logic [15:0] wdata, wmask_n, rdata, exp_rd; // Port data
	logic [1:0]  wc, rc;  // Width codes in force
	logic        mem_m [4096]; // Expected storage bits
	int          errors, n_tests, n_wr, n_rd, cycles, top; // Counters

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	dual_port_ram_cell dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .write_clk(wclk), .write_clk_enable(wce), .write_enable(wen),
		.write_addr_bus(waddr), .write_data_bus(wdata), .write_mask_n(wmask_n),
		.read_clk(rclk), .read_clk_enable(rce), .read_enable(ren), .read_addr_bus(raddr),
		.read_data_bus(rdata));

	fabric_port_model drv (.core_clk(core_clk), .wr_code(wc), .rd_code(rc), .write_clk(wclk),
		.write_clk_enable(wce), .write_enable(wen), .write_addr_bus(waddr),
		.write_data_bus(wdata), .write_mask_n(wmask_n), .read_clk(rclk),
		.read_clk_enable(rce), .read_enable(ren), .read_addr_bus(raddr));

	//------------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------------
	task automatic finish_test();
		$display("errors %0d, comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask : check

	// One APB transfer, waits for pready; only the hang guard ends a wait
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Sets both width codes
	task automatic cfg(input logic [1:0] w, input logic [1:0] r);
		apb(1'b1, ram_pkg::OFF_CFG, {26'h000_0000, r, 2'h0, w});
		check(err, 1'b0);
		wc = w;
		rc = r;
	endtask : cfg

	// Port write, mirrored in the bit model when taken
	task automatic mwrite(input logic [10:0] a, input logic [15:0] w, input logic [15:0] m,
		input logic ce, input logic en, input logic inv);
		int wb;
		wb = 2 << wc;
		drv.port_write(a, w, m, ce, en, inv);
		a = a & (11'h7ff >> wc);
		if (ce && en) n_wr++;
		for (int i = 0; i < wb; i++)
			if (ce && en && (wc != ram_pkg::W16 || !m[i])) mem_m[a * wb + i] = w[i];
	endtask : mwrite

	// Port read and compare; output holds when not taken
	task automatic mread(input logic [10:0] a, input logic ce, input logic en, input logic inv);
		int          wb;
		logic [15:0] w;
		wb = 2 << rc;
		w = 16'h0000;
		drv.port_read(a, ce, en, inv);
		a = a & (11'h7ff >> rc);
		for (int i = 0; i < wb; i++) w[i] = mem_m[a * wb + i];
		if (ce && en) begin
			n_rd++;
			exp_rd = drv.spread(w, rc);
		end
		check(rdata, exp_rd);
	endtask : mread

	//------------------------------------------------------------------
	// Hang guard
	//------------------------------------------------------------------
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end

	//------------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------------
	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		{errors, n_tests, n_wr, n_rd, cycles} = '0;
		wc = 2'h3;
		rc = 2'h3;
		exp_rd = 16'h0000;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge core_clk);
		check(rdata, 16'h0000); // Read output clear after reset
		apb(1'b0, ram_pkg::OFF_CFG, 32'h0000_0000);
		check(rd, 32'h0000_0033); // Both widths 16-bit after reset
		apb(1'b1, 12'h008, 32'h0000_0000);
		check(err, 1'b1); // Unmapped write refused
		apb(1'b0, 12'h008, 32'h0000_0000);
		check(err, 1'b1); // Unmapped read refused
		check(rd, 32'h0000_0000); // Unmapped read returns zero
		// Every width, first and last word
		for (int c = 0; c < 4; c++) begin
			cfg(c[1:0], c[1:0]);
			top = (2048 >> c) - 1;
			mwrite(11'h000, 16'h5a3c & ram_pkg::WORD_ONES[c], 16'h0000, 1, 1, 0);
			mwrite(top[10:0], 16'h96c3 & ram_pkg::WORD_ONES[c], 16'h0000, 1, 1, 0);
			mread(11'h000, 1, 1, 0);
			mread(top[10:0], 1, 1, 0);
		end
		// Write 8-bit, read 4-bit
		cfg(ram_pkg::W8, ram_pkg::W4);
		mwrite(11'h005, 16'h00a7, 16'h0000, 1, 1, 0);
		mread(11'h00a, 1, 1, 0);
		mread(11'h00b, 1, 1, 0);
		// Bit mask in 16-bit mode
		cfg(ram_pkg::W16, ram_pkg::W16);
		mwrite(11'h003, 16'hffff, 16'h0000, 1, 1, 0);
		mwrite(11'h003, 16'h0000, 16'h00ff, 1, 1, 0);
		mread(11'h003, 1, 1, 0);
		// Clock enable and enables gate each port
		mwrite(11'h003, 16'h1234, 16'h0000, 0, 1, 0);
		mwrite(11'h003, 16'h4321, 16'h0000, 1, 0, 0);
		mread(11'h000, 0, 1, 0);
		mread(11'h000, 1, 0, 0);
		mread(11'h003, 1, 1, 0);
		// Inverted clock pins
		drv.set_idle(1'b1);
		mwrite(11'h009, 16'hc3e1, 16'h0000, 1, 1, 1);
		mread(11'h009, 1, 1, 1);
		drv.set_idle(1'b0);
		// Counters of taken accesses
		apb(1'b0, ram_pkg::OFF_STAT, 32'h0000_0000);
		check(rd, {n_rd[15:0], n_wr[15:0]}); // Taken write and read counts
		finish_test();
	end
endmodule : dual_port_ram_cell_tb
